// ### src/mixer_router.sv
// What this block does
// - the mixer takes four independently selected sources, each with its own gain.
// - gain code 7 bits at bits 7:1, -32..+16 dB in 1 dB steps, 40h unity, clamped outside.
// - source code 00h is silence and default; 04h/05h tones, 06h haptic, 0Dh noise.
// - codes 10h..13h select the four microphone paths, in code order.
// - codes 70h..75h select channels 1..6 of the second DSP core.
// - codes 78h..7Dh select channels 1..6 of the third DSP core.
// - bit 15 of each source register reads 1 when that input path is enabled.
// - converter and aux inputs share the source coding and only pass one source.
// - two fixed 1 kHz tone generators are selectable sources.
// - a white noise generator is a selectable source.
// - two pulse-width generators, duty set by a selected source, drive pins.
// - enabling a path beyond the clock budget fails, others stay, error flagged.
`timescale 1ns/1ps
`default_nettype none
module mixer_router
(
  input  wire logic                                              clk,
  input  wire logic                                              reset,
  input  wire logic                                              sample_tick,
  input  wire logic [mixer_pkg::NUM_EXT*mixer_pkg::SAMPLE_W-1:0] ext_sources,
  input  wire logic [mixer_pkg::SAMPLE_W-1:0]                    haptic_sample,
  input  wire logic                                              hsel,
  input  wire logic [31:0]                                       haddr,
  input  wire logic [1:0]                                        htrans,
  input  wire logic                                              hwrite,
  input  wire logic [2:0]                                        hsize,
  input  wire logic [31:0]                                       hwdata,
  input  wire logic                                              hready,
  output logic      [31:0]                                       hrdata,
  output logic                                                   hreadyout,
  output logic                                                   hresp,
  output logic      [mixer_pkg::SAMPLE_W-1:0]                    mix_out,
  output logic      [mixer_pkg::SAMPLE_W-1:0]                    conv_out,
  output logic      [mixer_pkg::SAMPLE_W-1:0]                    aux_out,
  output logic      [1:0]                                        pwm_pins,
  output logic                                                   irq
);
  import mixer_pkg::*;

  // map a source code to a sample; unmapped codes give silence
  function automatic logic [SAMPLE_W-1:0] pick(
    input logic [7:0] code,
    input logic [NUM_EXT*SAMPLE_W-1:0] ext,
    input logic [SAMPLE_W-1:0] t1,
    input logic [SAMPLE_W-1:0] t2,
    input logic [SAMPLE_W-1:0] hap,
    input logic [SAMPLE_W-1:0] nz
  );
    logic [SAMPLE_W-1:0] v;
    v = '0;
    if (code == SRC_TONE1) v = t1;
    else if (code == SRC_TONE2) v = t2;
    else if (code == SRC_HAPTIC) v = hap;
    else if (code == SRC_NOISE) v = nz;
    else if (code >= SRC_MIC_BASE && code <= SRC_MIC_LAST)
      v = ext[SAMPLE_W*32'(code - SRC_MIC_BASE) +: SAMPLE_W];
    else if (code >= SRC_DSP2_BASE && code <= SRC_DSP2_LAST)
      v = ext[SAMPLE_W*(32'(code - SRC_DSP2_BASE) + 8) +: SAMPLE_W];
    else if (code >= SRC_DSP3_BASE && code <= SRC_DSP3_LAST)
      v = ext[SAMPLE_W*(32'(code - SRC_DSP3_BASE) + 16) +: SAMPLE_W];
    else if (code >= 8'h20 && code <= 8'h3F)
      v = ext[SAMPLE_W*(32'(code - 8'h20) + 32) +: SAMPLE_W];
    return v;
  endfunction

  // registers
  logic [7:0]  src_code [NUM_IN];
  logic [6:0]  gain_code [NUM_IN];
  logic [7:0]  sel_code [4];
  logic [NUM_IN-1:0] want;
  logic [NUM_IN-1:0] enabled;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [15:0] budget;
  logic [15:0] pwm_period;

  // bus address phase capture
  logic        ph_write;
  logic        ph_valid;
  logic [11:0] ph_addr;
  wire         take = hsel && hready && htrans[1];
  wire [11:0]  wa = ph_addr;
  wire         wr = ph_valid && ph_write;
  wire [3:0]   wr_src;
  wire [3:0]   wr_gain;
  wire [3:0]   wr_sel;
  wire         wr_ctrl = wr && wa == ADDR_CTRL;
  wire         wr_status = wr && wa == ADDR_STATUS;
  wire         wr_mask = wr && wa == ADDR_MASK;
  wire         wr_budget = wr && wa == ADDR_BUDGET;
  wire         wr_pwm = wr && wa == ADDR_PWM;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_dec
      assign wr_src[gi] = wr && wa == ADDR_SRC0 + 12'(4 * gi);
      assign wr_gain[gi] = wr && wa == ADDR_GAIN0 + 12'(4 * gi);
      assign wr_sel[gi] = wr && wa == ADDR_SEL0 + 12'(4 * gi);
    end
  endgenerate

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= '0;
    end
    else if (hready)
    begin
      ph_valid <= take;
      ph_write <= hwrite;
      ph_addr <= {haddr[11:2], 2'b00};
    end
  end

  // enable request with clock budget check
  function automatic logic [4:0] count_on(input logic [NUM_IN-1:0] v);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < NUM_IN; i++)
      c = c + 5'(v[i]);
    return c;
  endfunction

  logic [NUM_IN-1:0] next_enabled;
  logic              reject_now;
  always_comb
  begin
    next_enabled = enabled & want;
    reject_now = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (want[i] && !enabled[i])
      begin
        if (16'(count_on(next_enabled)) * COST_PER_PATH + COST_PER_PATH <= budget)
          next_enabled[i] = 1'b1;
        else
          reject_now = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_IN; i++)
      begin
        src_code[i] <= SRC_RESET;
        gain_code[i] <= GAIN_RESET;
      end
      for (int i = 0; i < 4; i++)
        sel_code[i] <= SRC_RESET;
      want <= '0;
      enabled <= '0;
      status <= '0;
      mask <= '0;
      budget <= BUDGET_RESET;
      pwm_period <= PWM_PERIOD_RESET;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wr_src[i]) src_code[i] <= hwdata[7:0];
        if (wr_gain[i]) gain_code[i] <= hwdata[GAIN_MSB:GAIN_LSB];
        if (wr_sel[i]) sel_code[i] <= hwdata[7:0];
      end
      if (wr_ctrl) want <= hwdata[NUM_IN-1:0];
      if (wr_mask) mask <= hwdata[1:0];
      if (wr_budget) budget <= hwdata[15:0];
      if (wr_pwm) pwm_period <= hwdata[15:0];
      enabled <= next_enabled;
      // set wins over write-one-clear
      status[EV_UNDERCLOCK] <= reject_now
        || (status[EV_UNDERCLOCK] && !(wr_status && hwdata[EV_UNDERCLOCK]));
      status[EV_REJECT] <= (reject_now && |(want & enabled))
        || (status[EV_REJECT] && !(wr_status && hwdata[EV_REJECT]));
    end
  end

  assign irq = |(status & mask);

  // read mux
  wire [11:0] ra = ph_addr;
  wire [1:0]  ri = ra[3:2];
  wire [31:0] rd =
      (ra[11:4] == ADDR_SRC0[11:4])
        ? {16'h0, enabled[ri], 7'h0, src_code[ri]}
    : (ra[11:4] == ADDR_GAIN0[11:4]) ? {24'h0, gain_code[ri], 1'b0}
    : (ra[11:4] == ADDR_SEL0[11:4]) ? {24'h0, sel_code[ri]}
    : (ra == ADDR_CTRL) ? {28'h0, want}
    : (ra == ADDR_STATUS) ? {30'h0, status}
    : (ra == ADDR_MASK) ? {30'h0, mask}
    : (ra == ADDR_BUDGET) ? {16'h0, budget}
    : (ra == ADDR_PWM) ? {16'h0, pwm_period}
    : 32'h0;
  assign hrdata = rd;

  // tone generators: 1 kHz square waves, second in quadrature
  logic [31:0] tone_cnt;
  logic [1:0]  tone_phase;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tone_cnt <= '0;
      tone_phase <= '0;
    end
    else if (tone_cnt == 32'(TONE_HALF / 2 - 1))
    begin
      tone_cnt <= '0;
      tone_phase <= tone_phase + 2'd1;
    end
    else
      tone_cnt <= tone_cnt + 32'd1;
  end
  wire [SAMPLE_W-1:0] tone1 = tone_phase[1] ? TONE_AMP : SAMPLE_W'(-TONE_AMP);
  wire [SAMPLE_W-1:0] tone2 = (tone_phase[1] ^ tone_phase[0])
    ? TONE_AMP : SAMPLE_W'(-TONE_AMP);

  // noise: 24-bit lfsr per sample
  logic [SAMPLE_W-1:0] lfsr;
  always_ff @(posedge clk)
  begin
    if (reset)
      lfsr <= LFSR_SEED;
    else if (sample_tick)
      lfsr <= {lfsr[SAMPLE_W-2:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
  end
  wire [SAMPLE_W-1:0] noise = {{3{lfsr[0]}}, lfsr[SAMPLE_W-4:0]};

  // mixer inputs
  logic [SAMPLE_W-1:0] in_sample [NUM_IN];
  logic [SAMPLE_W+3:0] in_scaled [NUM_IN];
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_in
      assign in_sample[gi] = enabled[gi]
        ? pick(src_code[gi], ext_sources, tone1, tone2, haptic_sample, noise)
        : '0;
      gain_stage u_gain
      (
        .sample    (in_sample[gi]),
        .gain_code (gain_code[gi]),
        .scaled    (in_scaled[gi])
      );
    end
  endgenerate

  logic signed [SAMPLE_W+5:0] acc;
  always_comb
  begin
    acc = '0;
    for (int i = 0; i < NUM_IN; i++)
      acc = acc + (SAMPLE_W+6)'(signed'(in_scaled[i]));
  end
  localparam logic signed [SAMPLE_W+5:0] FS_MAX = (SAMPLE_W+6)'(2 ** (SAMPLE_W-1) - 1);
  localparam logic signed [SAMPLE_W+5:0] FS_MIN = -FS_MAX - 1;
  wire [SAMPLE_W-1:0] sat = (acc > FS_MAX) ? FS_MAX[SAMPLE_W-1:0]
    : (acc < FS_MIN) ? FS_MIN[SAMPLE_W-1:0] : acc[SAMPLE_W-1:0];

  // pulse-width generators, duty from selected sources
  logic [15:0] pwm_cnt;
  // offset-binary top bits of the source scale the period; wide product, no wrap
  function automatic logic [15:0] duty_of(
    input logic [SAMPLE_W-1:0] s,
    input logic [15:0] p
  );
    logic [24:0] prod;
    prod = 25'({~s[SAMPLE_W-1], s[SAMPLE_W-2:SAMPLE_W-9]}) * 25'(p);
    return prod[24:9];
  endfunction

  wire [SAMPLE_W-1:0] pwm_src0 =
    pick(sel_code[2], ext_sources, tone1, tone2, haptic_sample, noise);
  wire [SAMPLE_W-1:0] pwm_src1 =
    pick(sel_code[3], ext_sources, tone1, tone2, haptic_sample, noise);
  wire [15:0] duty0 = duty_of(pwm_src0, pwm_period);
  wire [15:0] duty1 = duty_of(pwm_src1, pwm_period);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mix_out <= '0;
      conv_out <= '0;
      aux_out <= '0;
      pwm_cnt <= '0;
      pwm_pins <= '0;
    end
    else
    begin
      if (sample_tick)
      begin
        mix_out <= sat;
        conv_out <= pick(sel_code[0], ext_sources, tone1, tone2, haptic_sample, noise);
        aux_out <= pick(sel_code[1], ext_sources, tone1, tone2, haptic_sample, noise);
      end
      pwm_cnt <= (pwm_cnt >= pwm_period) ? 16'h0 : pwm_cnt + 16'd1;
      pwm_pins <= {pwm_cnt < duty1, pwm_cnt < duty0};
    end
  end

  wire all_silent = (src_code[0] == SRC_SILENCE) && (src_code[1] == SRC_SILENCE)
    && (src_code[2] == SRC_SILENCE) && (src_code[3] == SRC_SILENCE);

  // request for path 0 that the budget check let through
  sequence s_enable_req;
    want[0] && !enabled[0] && !reject_now;
  endsequence

  a_status_sticky: assert property (@(posedge clk) disable iff (reset)
    reject_now |=> status[EV_UNDERCLOCK])
    else $error("underclock not flagged");
  a_active_kept: assert property (@(posedge clk) disable iff (reset)
    (enabled[0] && want[0] && !wr_ctrl) |=> enabled[0])
    else $error("active path dropped");
  a_status_clear: assert property (@(posedge clk) disable iff (reset)
    (wr_status && hwdata[EV_UNDERCLOCK] && !reject_now) |=> !status[EV_UNDERCLOCK])
    else $error("underclock flag not cleared");
  a_enable_next: assert property (@(posedge clk) disable iff (reset)
    s_enable_req |=> enabled[0])
    else $error("accepted path not enabled");
  a_over_budget: assert property (@(posedge clk) disable iff (reset)
    (16'(count_on(enabled & want)) >= budget && want[2] && !enabled[2]) |=> !enabled[2])
    else $error("path enabled beyond budget");
  a_silence_src: assert property (@(posedge clk) disable iff (reset)
    (sample_tick && all_silent) |=> mix_out == '0)
    else $error("silence not silent");
  a_pwm_zero: assert property (@(posedge clk) disable iff (reset)
    (duty0 == 16'h0000) |=> !pwm_pins[0])
    else $error("pulse with zero duty");
  a_gain_reset: assert property (@(posedge clk)
    $fell(reset) |-> gain_code[0] == GAIN_RESET)
    else $error("gain reset wrong");
  a_bus_okay: assert property (@(posedge clk) hreadyout && !hresp)
    else $error("bus answer not okay");
endmodule
`default_nettype wire

// ### src/mixer_pkg.sv
package mixer_pkg;
  localparam int SAMPLE_W = 24;
  localparam int CODE_W = 8;
  localparam int NUM_IN = 4;
  localparam int NUM_EXT = 64;

  // byte addresses of the registers
  localparam logic [11:0] ADDR_SRC0 = 12'h000;
  localparam logic [11:0] ADDR_GAIN0 = 12'h010;
  localparam logic [11:0] ADDR_SEL0 = 12'h020;
  localparam logic [11:0] ADDR_CTRL = 12'h030;
  localparam logic [11:0] ADDR_STATUS = 12'h034;
  localparam logic [11:0] ADDR_MASK = 12'h038;
  localparam logic [11:0] ADDR_BUDGET = 12'h03C;
  localparam logic [11:0] ADDR_PWM = 12'h040;

  localparam int ENABLED_BIT = 15;
  localparam int GAIN_LSB = 1;
  localparam int GAIN_MSB = 7;
  localparam logic [6:0] GAIN_RESET = 7'h40;
  localparam logic [6:0] GAIN_MIN_CODE = 7'h20;
  localparam logic [6:0] GAIN_MAX_CODE = 7'h50;
  localparam logic [7:0] SRC_RESET = 8'h00;

  // source codes
  localparam logic [7:0] SRC_SILENCE = 8'h00;
  localparam logic [7:0] SRC_TONE1 = 8'h04;
  localparam logic [7:0] SRC_TONE2 = 8'h05;
  localparam logic [7:0] SRC_HAPTIC = 8'h06;
  localparam logic [7:0] SRC_NOISE = 8'h0D;
  localparam logic [7:0] SRC_MIC_BASE = 8'h10;
  localparam logic [7:0] SRC_MIC_LAST = 8'h13;
  localparam logic [7:0] SRC_DSP2_BASE = 8'h70;
  localparam logic [7:0] SRC_DSP2_LAST = 8'h75;
  localparam logic [7:0] SRC_DSP3_BASE = 8'h78;
  localparam logic [7:0] SRC_DSP3_LAST = 8'h7D;

  // status bits
  localparam int EV_UNDERCLOCK = 0;
  localparam int EV_REJECT = 1;

  // tone: 1 kHz from 200 MHz clock
  localparam int CLK_HZ = 200_000_000;
  localparam int TONE_HZ = 1000;
  localparam int TONE_HALF = CLK_HZ / (2 * TONE_HZ);
  localparam logic [SAMPLE_W-1:0] TONE_AMP = 24'h20_0000;
  localparam logic [15:0] BUDGET_RESET = 16'h0010;
  localparam logic [15:0] COST_PER_PATH = 16'h0001;
  localparam logic [15:0] PWM_PERIOD_RESET = 16'h00FF;
  localparam logic [SAMPLE_W-1:0] LFSR_SEED = 24'h00_0001;
endpackage

// ### src/gain_stage.sv
`timescale 1ns/1ps
`default_nettype none
// gain in 1 dB steps: factor 2^(db/6) via 6-entry fraction table and shift
module gain_stage
(
  input  wire logic [mixer_pkg::SAMPLE_W-1:0] sample,
  input  wire logic [6:0]                     gain_code,
  output logic      [mixer_pkg::SAMPLE_W+3:0] scaled
);
  import mixer_pkg::*;
  logic signed [6:0]          db;
  logic [6:0]                 clamped;
  logic signed [6:0]          sixths;
  logic signed [6:0]          rem;
  logic [15:0]                frac;
  logic signed [SAMPLE_W+19:0] prod;
  logic signed [SAMPLE_W+19:0] shifted;

  assign clamped = (gain_code <= GAIN_MIN_CODE) ? GAIN_MIN_CODE
                 : (gain_code >= GAIN_MAX_CODE) ? GAIN_MAX_CODE : gain_code;
  assign db = 7'(signed'(clamped) - signed'(GAIN_RESET));
  // floor divide by 6 for -32..+16
  assign sixths = (db >= 0) ? 7'(db / 6) : 7'(-((-db + 5) / 6));
  assign rem = 7'(db - 7'(sixths * 6));
  always_comb
  begin
    case (rem)
      7'sd0: frac = 16'h8000;
      7'sd1: frac = 16'h8F9E;
      7'sd2: frac = 16'hA145;
      7'sd3: frac = 16'hB505;
      7'sd4: frac = 16'hCB59;
      default: frac = 16'hE429;
    endcase
  end
  assign prod = (SAMPLE_W+20)'(signed'(sample) * signed'({1'b0, frac}));
  assign shifted = (sixths >= 0) ? (prod <<< sixths) : (prod >>> (-sixths));
  assign scaled = shifted[SAMPLE_W+18:15];
endmodule
`default_nettype wire

// ### testbench/source_model.sv
`timescale 1ns/1ps
`default_nettype none
module source_model
(
  input  wire logic                                              clk,
  input  wire logic                                              update,
  input  wire logic [1:0]                                        mode,
  output logic      [mixer_pkg::NUM_EXT*mixer_pkg::SAMPLE_W-1:0] ext_sources,
  output logic      [mixer_pkg::SAMPLE_W-1:0]                    haptic_sample
);
  import mixer_pkg::*;
  integer seed = 32'h6ce2;

  // full scale in mode 1 and 2, else random with two clear low bits
  function automatic logic [SAMPLE_W-1:0] pick(input logic [1:0] m);
    if (m == 2'd1)
      return 24'h7F_FFFF;
    if (m == 2'd2)
      return 24'h80_0000;
    return 24'($random(seed)) & 24'hFF_FFFC;
  endfunction

  initial
  begin
    ext_sources = '0;
    haptic_sample = '0;
  end

  // every slot moves on the same frame, so all sources share one rate
  always @(posedge clk)
    if (update)
    begin
      for (int k = 0; k < NUM_EXT; k++)
        ext_sources[k*SAMPLE_W +: SAMPLE_W] <= pick(mode);
      haptic_sample <= pick(mode);
    end
endmodule
`default_nettype wire

// ### testbench/digital_core_mixer_router_test.sv
`timescale 1ns/1ps
`default_nettype none
module digital_core_mixer_router_test;
  import mixer_pkg::*;
  logic                        clk = 1'b0;
  logic                        reset = 1'b1;
  logic                        sample_tick = 1'b0;
  logic                        hsel = 1'b0;
  logic                        hwrite = 1'b0;
  logic                        update = 1'b0;
  logic [31:0]                 haddr = '0;
  logic [31:0]                 hwdata = '0;
  logic [1:0]                  htrans = '0;
  logic [1:0]                  mode = '0;
  logic [2:0]                  hsize = 3'b010;
  wire logic [31:0]            hrdata;
  wire logic                   hreadyout;
  wire logic                   hresp;
  wire logic                   irq;
  wire logic [SAMPLE_W-1:0]    mix_out;
  wire logic [SAMPLE_W-1:0]    conv_out;
  wire logic [SAMPLE_W-1:0]    aux_out;
  wire logic [SAMPLE_W-1:0]    haptic_sample;
  wire logic [NUM_EXT*SAMPLE_W-1:0] ext_sources;
  wire logic [1:0]             pwm_pins;
  integer                      seed = 32'h6ce2;
  int                          miscompares = 0;
  int                          total_checks = 0;
  int                          n0 = 0;
  int                          n1 = 0;
  int                          g[4];
  logic [31:0]                 rv;
  logic [7:0]                  c[4];
  longint                      acc;
  logic [6:0] gtab[5] = '{7'h34, 7'h3A, 7'h40, 7'h46, 7'h4C};
  logic [7:0] ctab[19] = '{8'h00, 8'h06, 8'h40, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D};
  logic [7:0] ntab[3] = '{SRC_TONE1, SRC_TONE2, SRC_NOISE};

  always #2.5 clk = ~clk;

  mixer_router dut (.clk(clk), .reset(reset), .sample_tick(sample_tick),
    .ext_sources(ext_sources), .haptic_sample(haptic_sample), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mix_out(mix_out),
    .conv_out(conv_out), .aux_out(aux_out), .pwm_pins(pwm_pins), .irq(irq));

  source_model far_end (.clk(clk), .update(update), .mode(mode),
    .ext_sources(ext_sources), .haptic_sample(haptic_sample));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_smp(input string n, input logic [23:0] e, input logic [23:0] s);
    chk_reg(n, {8'h00, e}, {8'h00, s});
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000);
    chk_reg(n, e, rv);
  endtask

  // high cycles of each pulse-width pin over two 16-clock periods
  task automatic pwm_count;
    n0 = 0;
    n1 = 0;
    repeat (32)
    begin
      @(posedge clk);
      n0 += int'(pwm_pins[0]);
      n1 += int'(pwm_pins[1]);
    end
  endtask

  // two ticks so any output pipeline has settled on constant sources
  task automatic tick;
    repeat (2)
    begin
      @(posedge clk) sample_tick <= 1'b1;
      @(posedge clk) sample_tick <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic frame(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    update <= 1'b1;
    @(posedge clk) update <= 1'b0;
    tick();
  endtask

  function automatic longint src_val(input logic [7:0] k);
    int s;
    s = (k inside {[SRC_MIC_BASE:SRC_MIC_LAST]}) ? int'(k) - 8'h10 :
        (k inside {[SRC_DSP2_BASE:SRC_DSP2_LAST]}) ? int'(k) - 8'h68 :
        (k inside {[SRC_DSP3_BASE:SRC_DSP3_LAST]}) ? int'(k) - 8'h68 : -1;
    if (k == SRC_HAPTIC)
      return longint'($signed(haptic_sample));
    if (s < 0)
      return 0;
    return longint'($signed(ext_sources[s*SAMPLE_W +: SAMPLE_W]));
  endfunction

  function automatic logic [23:0] sat(input longint x);
    if (x > 64'sd8388607)
      return 24'h7F_FFFF;
    if (x < -64'sd8388608)
      return 24'h80_0000;
    return x[23:0];
  endfunction

  initial
  begin
    #200_000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_SRC0, 32'h0000_0000, "src0 reset");
    rd(ADDR_GAIN0, 32'h0000_0080, "gain0 reset");
    rd(ADDR_BUDGET, 32'h0000_0010, "budget reset");
    bus(1'b1, 12'h100, 32'hFFFF_FFFF);
    rd(12'h100, 32'h0000_0000, "unmapped");
    frame(2'd0);
    foreach (ctab[i])
    begin
      bus(1'b1, ADDR_SEL0, {24'h00_0000, ctab[i]});
      bus(1'b1, ADDR_SEL0 + 12'h004, {24'h00_0000, ctab[i]});
      tick();
      chk_smp("conv", sat(src_val(ctab[i])), conv_out);
      chk_smp("aux", sat(src_val(ctab[i])), aux_out);
    end
    foreach (ntab[i])
    begin
      bus(1'b1, ADDR_SEL0, {24'h00_0000, ntab[i]});
      tick();
      chk_smp("generator live", 24'h00_0001, {23'h0, conv_out !== 24'h00_0000});
    end
    bus(1'b1, ADDR_PWM, 32'h0000_000F);
    bus(1'b1, ADDR_SEL0 + 12'h008, 32'h0000_0010);
    frame(2'd2);
    pwm_count();
    chk_reg("pwm low", 32'h0000_0000, 32'(n0));
    frame(2'd1);
    pwm_count();
    chk_reg("pwm order", 32'h0000_0001, {31'h0, n0 > n1 && n1 > 0});
    bus(1'b1, ADDR_CTRL, 32'h0000_000F);
    repeat (12)
    begin
      for (int j = 0; j < 4; j++)
      begin
        c[j] = ctab[3 + ($unsigned($random(seed)) % 16)];
        g[j] = $unsigned($random(seed)) % 5;
        bus(1'b1, ADDR_SRC0 + 12'(4 * j), {24'h00_0000, c[j]});
        bus(1'b1, ADDR_GAIN0 + 12'(4 * j), {24'h00_0000, gtab[g[j]], 1'b0});
      end
      frame(2'($random(seed)));
      acc = 0;
      for (int j = 0; j < 4; j++)
        acc += g[j] >= 2 ? src_val(c[j]) <<< (g[j] - 2) : src_val(c[j]) >>> (2 - g[j]);
      chk_smp("mix", sat(acc), mix_out);
      rd(ADDR_SRC0 + 12'h00C, {16'h0000, 8'h80, c[3]}, "src3 enabled");
    end
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    bus(1'b1, ADDR_BUDGET, 32'h0000_0002);
    bus(1'b1, ADDR_CTRL, 32'h0000_0001);
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    bus(1'b1, ADDR_CTRL, 32'h0000_0007);
    rd(ADDR_SRC0 + 12'h004, 32'h0000_8000, "src1 enabled");
    rd(ADDR_SRC0 + 12'h008, 32'h0000_0000, "src2 enabled");
    rd(ADDR_STATUS, 32'h0000_0003, "status");
    bus(1'b1, ADDR_STATUS, 32'h0000_0003);
    rd(ADDR_STATUS, 32'h0000_0003, "status set wins");
    chk_reg("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    bus(1'b1, ADDR_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk_reg("irq", 32'h1, {31'h0, irq});
    bus(1'b1, ADDR_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk_reg("irq cleared", 32'h0, {31'h0, irq});
    end_of_test();
  end
endmodule
`default_nettype wire
